// >>> rtl/mpsc_consts.svh
// constants for the module power sequencing control block
//
// Summary of operation
// - fabric_rails_good high only when fabric rails good
// - ps_io_supply_enable active high, low when inactive
// - fabric_io_supply_enable active high, low when inactive
// - internal rails sequence before any io enable; leaving MPSC_FAB_OFF, fabric_rails_enable rises with fabric_io_supply_enable
// - ps io enable asserted first
// - fabric io enable asserted after ps enable
// - fabric power pin low powers fabric off
// - fabric power pin high again powers fabric on
// - fabric power pin defaults high via pull-up
// - shutdown pin falling edge powers everything down
// - shutdown pin ignored until reset released
// - nine platform-manager pins: six in, three out
// - two pins reserved for power management
// - unclaimed platform-manager pins stay ordinary io
// - power-down request does ordered silent shutdown
// - hold power-on reset until rails stable
`ifndef MPSC_CONSTS_SVH
`define MPSC_CONSTS_SVH

// register byte offsets
`define MPSC_OFS_CTRL 12'h000
`define MPSC_OFS_STATUS 12'h004
`define MPSC_OFS_IRQ_STAT 12'h008
`define MPSC_OFS_IRQ_MASK 12'h00C
`define MPSC_OFS_PIN_OUT 12'h010
`define MPSC_OFS_PIN_IN 12'h014
`define MPSC_OFS_PIN_CLAIM 12'h018

// control fields
`define MPSC_CTRL_SW_SHUTDOWN 0
`define MPSC_CTRL_FABRIC_OFF 1

// interrupt events
`define MPSC_EV_UP 0
`define MPSC_EV_DOWN 1
`define MPSC_EV_FABRIC 2
`define MPSC_EV_SHUTDOWN 3
`define MPSC_EV_COUNT 4

// reset values
`define MPSC_CTRL_RESET 32'h0000_0000
`define MPSC_MASK_RESET 4'h0

// timing in ns, each step of the sequence
`define MPSC_CLK_NS 10
`define MPSC_RAIL_STEP_NS 1000
`define MPSC_IO_STEP_NS 500
`define MPSC_POR_HOLD_NS 2000

`endif

// >>> rtl/mpsc_pkg.sv
// types for the module power sequencing control block
package mpsc_pkg;

  // main sequencer states
  typedef enum logic [3:0] {
    MPSC_OFF = 4'b0000,
    MPSC_RAILS_UP = 4'b0001,
    MPSC_PS_IO_UP = 4'b0010,
    MPSC_FABRIC_IO_UP = 4'b0011,
    MPSC_POR_HOLD = 4'b0100,
    MPSC_RUN = 4'b0101,
    MPSC_FABRIC_IO_DOWN = 4'b0110,
    MPSC_PS_IO_DOWN = 4'b0111,
    MPSC_RAILS_DOWN = 4'b1000,
    MPSC_FAB_OFF = 4'b1001
  } mpsc_state_e;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mpsc_apb_req_s;

  // supply outputs toward the carrier
  typedef struct packed {
    logic fabric_rails_good;
    logic ps_io_supply_enable;
    logic fabric_io_supply_enable;
    logic ps_power_on_reset_n;
  } mpsc_supply_s;

endpackage

// >>> rtl/mpsc_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module mpsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage read only by second stage
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// >>> rtl/mpsc_timer.sv
// one-shot down counter, pulses done when a loaded count expires
`timescale 1ns/100ps
module mpsc_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);

  logic [WIDTH-1:0] cnt_reg;
  logic run_reg;

  // load wins over running; done is one cycle after the last count
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      run_reg <= 1'b1;
      done <= 1'b0;
    end else if (run_reg) begin
      if (cnt_reg <= WIDTH'(1)) begin
        run_reg <= 1'b0;
        done <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - WIDTH'(1);
        done <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end

endmodule

// >>> rtl/mpsc_top.sv
// module power sequencer with apb registers and platform-manager pins
`timescale 1ns/100ps
`include "mpsc_consts.svh"
module mpsc_top
  import mpsc_pkg::*;
#(
  parameter int RAIL_STEP_CYCLES = (`MPSC_RAIL_STEP_NS + `MPSC_CLK_NS - 1) / `MPSC_CLK_NS,
  parameter int IO_STEP_CYCLES = (`MPSC_IO_STEP_NS + `MPSC_CLK_NS - 1) / `MPSC_CLK_NS,
  parameter int POR_HOLD_CYCLES = (`MPSC_POR_HOLD_NS + `MPSC_CLK_NS - 1) / `MPSC_CLK_NS,
  parameter int IN_PINS = 6,
  parameter int OUT_PINS = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // carrier side pins
  input wire logic power_off_request_n,
  input wire logic power_down_request_n,
  input wire logic fabric_rails_in_regulation,
  input wire logic ps_power_on_reset_in,
  output logic fabric_rails_good,
  output logic ps_io_supply_enable,
  output logic fabric_io_supply_enable,
  output logic ps_power_on_reset_n,
  output logic ps_power_on_reset_oe,
  // platform-manager multiplexed io
  input wire logic fabric_domain_power_on,
  input wire logic shutdown_request_pin,
  input wire logic [IN_PINS-1:0] pm_gpi,
  input wire logic [OUT_PINS-1:0] mux_io_out,
  output logic [OUT_PINS-1:0] pm_gpo,
  output logic [OUT_PINS-1:0] pm_gpo_oe,
  // internal regulators and interrupt
  output logic rails_enable,
  output logic fabric_rails_enable,
  output logic irq
);

  localparam int TW = 16;

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [5:0] raw_pins;
  logic [5:0] sync_pins;
  logic [IN_PINS-1:0] gpi_sync;
  logic off_req_n_s, pdown_n_s, fab_reg_s, por_in_s, fab_on_s, shut_s;

  assign raw_pins = {power_off_request_n, power_down_request_n, fabric_rails_in_regulation,
                     ps_power_on_reset_in, fabric_domain_power_on, shutdown_request_pin};
  assign {off_req_n_s, pdown_n_s, fab_reg_s, por_in_s, fab_on_s, shut_s} = sync_pins;

  // pulled-up pins rest high so a floating pin keeps fabric powered; the reserved
  // power-management pins stay dedicated inputs, never part of the gpio groups
  mpsc_sync #(.WIDTH(6), .RESET_VAL(6'h17)) u_sync_pins (
    .clock(clock),
    .reset(reset),
    .async_in(raw_pins),
    .sync_out(sync_pins)
  );

  mpsc_sync #(.WIDTH(IN_PINS), .RESET_VAL('0)) u_sync_gpi (
    .clock(clock),
    .reset(reset),
    .async_in(pm_gpi),
    .sync_out(gpi_sync)
  );

  // ***************************************************************
  // registers and edge detection
  // ***************************************************************
  logic [31:0] ctrl_reg;
  logic [`MPSC_EV_COUNT-1:0] irq_stat_reg, irq_mask_reg, ev_set;
  logic [OUT_PINS-1:0] pin_out_reg, pin_claim_reg;
  logic shut_prev_reg, fab_on_prev_reg, shut_armed_reg;
  logic shut_fall, fab_fall, fab_rise, fabric_want;
  mpsc_state_e state_reg, state_next;
  logic tmr_load, tmr_done;
  logic [TW-1:0] tmr_count;
  logic apb_wr, apb_rd, addr_ok;

  // previous pin levels for edge detection
  always_ff @(posedge clock) begin
    if (reset) begin
      shut_prev_reg <= 1'b0;
      fab_on_prev_reg <= 1'b1;
    end else begin
      shut_prev_reg <= shut_s;
      fab_on_prev_reg <= fab_on_s;
    end
  end

  // shutdown pin is dead until power-on reset has been released
  always_ff @(posedge clock) begin
    if (reset || state_reg == MPSC_OFF) begin
      shut_armed_reg <= 1'b0;
    end else if (state_reg == MPSC_RUN || state_reg == MPSC_FAB_OFF) begin
      shut_armed_reg <= 1'b1;
    end
  end

  assign shut_fall = shut_armed_reg && shut_prev_reg && !shut_s;
  assign fab_fall = fab_on_prev_reg && !fab_on_s;
  assign fab_rise = !fab_on_prev_reg && fab_on_s;
  assign fabric_want = fab_on_s && !ctrl_reg[`MPSC_CTRL_FABRIC_OFF];

  // ***************************************************************
  // main sequencer
  // ***************************************************************
  logic pwr_cut;
  assign pwr_cut = !off_req_n_s || !pdown_n_s || shut_fall
                   || ctrl_reg[`MPSC_CTRL_SW_SHUTDOWN];

  always_comb begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_count = TW'(RAIL_STEP_CYCLES);
    unique case (state_reg)
      MPSC_OFF: begin
        // carrier releases the request only once main supply is valid
        if (off_req_n_s && pdown_n_s && !ctrl_reg[`MPSC_CTRL_SW_SHUTDOWN]) begin
          state_next = MPSC_RAILS_UP;
          tmr_load = 1'b1;
        end
      end
      MPSC_RAILS_UP: begin
        if (pwr_cut) begin
          state_next = MPSC_RAILS_DOWN;
          tmr_load = 1'b1;
        end else if (tmr_done) begin
          state_next = MPSC_PS_IO_UP;
          tmr_load = 1'b1;
          tmr_count = TW'(IO_STEP_CYCLES);
        end
      end
      MPSC_PS_IO_UP: begin
        if (pwr_cut) begin
          state_next = MPSC_PS_IO_DOWN;
          tmr_load = 1'b1;
          tmr_count = TW'(IO_STEP_CYCLES);
        end else if (tmr_done) begin
          state_next = MPSC_FABRIC_IO_UP;
          tmr_load = 1'b1;
          tmr_count = TW'(POR_HOLD_CYCLES);
        end
      end
      MPSC_FABRIC_IO_UP, MPSC_POR_HOLD: begin
        if (pwr_cut) begin
          state_next = MPSC_FABRIC_IO_DOWN;
          tmr_load = 1'b1;
          tmr_count = TW'(IO_STEP_CYCLES);
        end else if (tmr_done || state_reg == MPSC_POR_HOLD) begin
          state_next = fabric_want ? MPSC_RUN : MPSC_FAB_OFF;
        end
      end
      MPSC_RUN: begin
        if (pwr_cut) begin
          state_next = MPSC_FABRIC_IO_DOWN;
          tmr_load = 1'b1;
          tmr_count = TW'(IO_STEP_CYCLES);
        end else if (fab_fall || !fabric_want) begin
          state_next = MPSC_FAB_OFF;
        end
      end
      MPSC_FAB_OFF: begin
        if (pwr_cut) begin
          state_next = MPSC_PS_IO_DOWN;
          tmr_load = 1'b1;
          tmr_count = TW'(IO_STEP_CYCLES);
        end else if (fab_rise || fabric_want) begin
          state_next = MPSC_POR_HOLD;
        end
      end
      MPSC_FABRIC_IO_DOWN: begin
        if (tmr_done) begin
          state_next = MPSC_PS_IO_DOWN;
          tmr_load = 1'b1;
          tmr_count = TW'(IO_STEP_CYCLES);
        end
      end
      MPSC_PS_IO_DOWN: begin
        if (tmr_done) begin
          state_next = MPSC_RAILS_DOWN;
          tmr_load = 1'b1;
        end
      end
      MPSC_RAILS_DOWN: begin
        if (tmr_done) begin
          state_next = MPSC_OFF;
        end
      end
      default: begin
        state_next = MPSC_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= MPSC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  mpsc_timer #(.WIDTH(TW)) u_timer (
    .clock(clock),
    .reset(reset),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // ***************************************************************
  // supply outputs, all registered
  // ***************************************************************
  logic in_up_path;
  assign in_up_path = state_next inside {MPSC_PS_IO_UP, MPSC_FABRIC_IO_UP, MPSC_POR_HOLD,
                                         MPSC_RUN, MPSC_FAB_OFF, MPSC_FABRIC_IO_DOWN};

  always_ff @(posedge clock) begin
    if (reset) begin
      rails_enable <= 1'b0;
      fabric_rails_enable <= 1'b0;
      ps_io_supply_enable <= 1'b0;
      fabric_io_supply_enable <= 1'b0;
      fabric_rails_good <= 1'b0;
      ps_power_on_reset_n <= 1'b0;
      ps_power_on_reset_oe <= 1'b1;
    end else begin
      rails_enable <= state_next != MPSC_OFF;
      fabric_rails_enable <= state_next inside {MPSC_RAILS_UP, MPSC_PS_IO_UP,
                                                MPSC_FABRIC_IO_UP, MPSC_POR_HOLD, MPSC_RUN};
      ps_io_supply_enable <= in_up_path;
      fabric_io_supply_enable <= state_next inside {MPSC_FABRIC_IO_UP, MPSC_POR_HOLD,
                                                    MPSC_RUN};
      fabric_rails_good <= fab_reg_s && state_next inside {MPSC_FABRIC_IO_UP,
                                                MPSC_POR_HOLD, MPSC_RUN};
      // open-drain: drive low until stable, then release for carrier use;
      // a fabric power-up after release must not reset the processing system again
      ps_power_on_reset_n <= 1'b0;
      ps_power_on_reset_oe <= !(state_next inside {MPSC_RUN, MPSC_FAB_OFF}
                              || (!ps_power_on_reset_oe && state_next == MPSC_POR_HOLD));
    end
  end

  // ***************************************************************
  // platform-manager output pins, claim selects owner
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      pm_gpo <= '0;
      pm_gpo_oe <= '0;
    end else begin
      for (int i = 0; i < OUT_PINS; i++) begin
        pm_gpo[i] <= pin_claim_reg[i] ? pin_out_reg[i] : mux_io_out[i];
        pm_gpo_oe[i] <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // apb slave and interrupts
  // ***************************************************************
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign addr_ok = paddr inside {`MPSC_OFS_CTRL, `MPSC_OFS_STATUS, `MPSC_OFS_IRQ_STAT,
                                 `MPSC_OFS_IRQ_MASK, `MPSC_OFS_PIN_OUT, `MPSC_OFS_PIN_IN,
                                 `MPSC_OFS_PIN_CLAIM};

  assign ev_set[`MPSC_EV_UP] = state_reg != MPSC_RUN && state_next == MPSC_RUN;
  assign ev_set[`MPSC_EV_DOWN] = state_reg != MPSC_OFF && state_next == MPSC_OFF;
  assign ev_set[`MPSC_EV_FABRIC] = state_reg != state_next
                                   && (state_next == MPSC_FAB_OFF || state_reg == MPSC_FAB_OFF);
  assign ev_set[`MPSC_EV_SHUTDOWN] = shut_fall;

  // writable registers; writes to the pin registers are taken in every power state
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_reg <= `MPSC_CTRL_RESET;
      irq_mask_reg <= `MPSC_MASK_RESET;
      pin_out_reg <= '0;
      pin_claim_reg <= '0;
    end else if (apb_wr) begin
      unique case (paddr)
        `MPSC_OFS_CTRL: ctrl_reg <= {30'h0, pwdata[1:0]};
        `MPSC_OFS_IRQ_MASK: irq_mask_reg <= pwdata[`MPSC_EV_COUNT-1:0];
        `MPSC_OFS_PIN_OUT: pin_out_reg <= pwdata[OUT_PINS-1:0];
        `MPSC_OFS_PIN_CLAIM: pin_claim_reg <= pwdata[OUT_PINS-1:0];
        default: ;
      endcase
    end
  end

  // sticky status: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((apb_wr && paddr == `MPSC_OFS_IRQ_STAT)
                      ? pwdata[`MPSC_EV_COUNT-1:0] : '0)) | ev_set;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // one wait-free answer: ready high in every access phase
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd) begin
        unique case (paddr)
          `MPSC_OFS_CTRL: prdata <= ctrl_reg;
          `MPSC_OFS_STATUS: prdata <= {21'h0, por_in_s, fab_on_s, shut_armed_reg,
                                       fabric_rails_good, fabric_io_supply_enable,
                                       ps_io_supply_enable, ps_power_on_reset_oe, state_reg};
          `MPSC_OFS_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
          `MPSC_OFS_IRQ_MASK: prdata <= {28'h0, irq_mask_reg};
          `MPSC_OFS_PIN_OUT: prdata <= {29'h0, pin_out_reg};
          `MPSC_OFS_PIN_IN: prdata <= {26'h0, gpi_sync};
          `MPSC_OFS_PIN_CLAIM: prdata <= {29'h0, pin_claim_reg};
          default: prdata <= '0;
        endcase
      end
    end
  end

endmodule

// >>> testbench/mpsc_checker.sv
// concurrent checks on the sequencer and bus ports of the top module
`timescale 1ns/100ps
module mpsc_checker #(
  parameter int IO_STEP = 3,
  parameter int RAIL_STEP = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // pins and regulators
  input wire logic shutdown_request_pin,
  input wire logic fabric_domain_power_on,
  input wire logic fabric_rails_good,
  input wire logic ps_io_supply_enable,
  input wire logic fabric_io_supply_enable,
  input wire logic ps_power_on_reset_oe,
  input wire logic rails_enable,
  input wire logic fabric_rails_enable
);
  // ****************
  // sequencer checks
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // longest full power-down: sync, two io steps, rail step, margin
  localparam int DOWN_MAX = 2 * IO_STEP + RAIL_STEP + 12;

  // zero wait states, so a setup is always answered next cycle
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("setup cycle not answered");
  good_off_a: assert property (!fabric_rails_enable [*3] |-> !fabric_rails_good)
    else $error("rails good while fabric regulators off");
  rails_first_a: assert property ($rose(ps_io_supply_enable) |-> $past(rails_enable, 2))
    else $error("io enable before internal rails");
  ps_first_a: assert property ($rose(fabric_io_supply_enable) |-> ps_io_supply_enable)
    else $error("fabric io enable without ps io enable");
  fab_follow_a: assert property ($rose(ps_io_supply_enable) |->
    !fabric_io_supply_enable [*2] ##[1:IO_STEP] fabric_io_supply_enable)
    else $error("fabric io enable not following ps io enable");
  down_order_a: assert property ($fell(ps_io_supply_enable) |->
    !fabric_io_supply_enable && !$past(fabric_io_supply_enable))
    else $error("ps io enable dropped before fabric io enable");
  por_late_a: assert property ($fell(ps_power_on_reset_oe) |->
    rails_enable && $past(ps_io_supply_enable, 8))
    else $error("reset released before rails stable");
  shut_down_a: assert property ($fell(shutdown_request_pin) && !ps_power_on_reset_oe &&
    ps_io_supply_enable |-> ##[1:DOWN_MAX] !ps_io_supply_enable && !rails_enable)
    else $error("shutdown edge did not power down");
  fab_off_a: assert property ($fell(fabric_domain_power_on) && !ps_power_on_reset_oe |->
    ##[1:20] !fabric_rails_enable && !fabric_io_supply_enable)
    else $error("fabric pin low did not power fabric off");
  fab_on_a: assert property ($rose(fabric_domain_power_on) && ps_io_supply_enable &&
    !ps_power_on_reset_oe |-> ##[1:40] fabric_io_supply_enable)
    else $error("fabric pin high did not power fabric on");
endmodule

bind mpsc_top mpsc_checker #(.IO_STEP(IO_STEP_CYCLES), .RAIL_STEP(RAIL_STEP_CYCLES))
  i_mpsc_checker (.clock, .reset, .psel, .penable, .pready,
  .shutdown_request_pin, .fabric_domain_power_on, .fabric_rails_good, .ps_io_supply_enable,
  .fabric_io_supply_enable, .ps_power_on_reset_oe, .rails_enable, .fabric_rails_enable);

// >>> testbench/mpsc_carrier_model.sv
// carrier card power manager model facing the module
`timescale 1ns/100ps
module mpsc_carrier_model (
  // clock and main supply
  input wire logic clock,
  input wire logic main_supply_ok,
  // from the module
  input wire logic fabric_rails_enable,
  input wire logic ps_power_on_reset_oe,
  // to the module
  output logic power_off_request_n,
  output logic fabric_rails_in_regulation,
  output logic ps_power_on_reset_in
);
  logic [3:0] ok_cnt = 4'h0;
  logic [1:0] reg_dly = 2'h0;
  // supply must settle eight cycles before the request is let go
  always @(posedge clock) begin
    ok_cnt <= !main_supply_ok ? 4'h0 : (ok_cnt[3] ? ok_cnt : ok_cnt + 4'h1);
    reg_dly <= {reg_dly[0], fabric_rails_enable};
  end
  assign power_off_request_n = ok_cnt[3];
  // regulators reach regulation two cycles after enable
  assign fabric_rails_in_regulation = reg_dly[1];
  // open-drain reset wire with pull-up
  assign ps_power_on_reset_in = !ps_power_on_reset_oe;
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the power sequencing block
`timescale 1ns/100ps
module testbench;
  logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic main_supply_ok = 1'b0, power_down_request_n = 1'b1, shutdown_request_pin = 1'b1;
  logic fab_drive = 1'b0, fab_val = 1'b0;
  logic [5:0] pm_gpi = 6'h0;
  logic [2:0] mux_io_out = 3'h0, pm_gpo, pm_gpo_oe, c, o;
  logic pready, pslverr, power_off_request_n, fabric_rails_in_regulation, ps_power_on_reset_in;
  logic fabric_rails_good, ps_io_supply_enable, fabric_io_supply_enable, ps_power_on_reset_n;
  logic ps_power_on_reset_oe, rails_enable, fabric_rails_enable, irq;
  wire fabric_domain_power_on = fab_drive ? fab_val : 1'b1; // pull-up
  logic [32:0] exp_q[$];
  int err_count = 0, cmp_count = 0, seed = 32'hE231;

  mpsc_top #(.RAIL_STEP_CYCLES(3), .IO_STEP_CYCLES(3), .POR_HOLD_CYCLES(20)) i_mpsc_top (
    .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_off_request_n, .power_down_request_n, .fabric_rails_in_regulation,
    .ps_power_on_reset_in, .fabric_rails_good, .ps_io_supply_enable, .fabric_io_supply_enable,
    .ps_power_on_reset_n, .ps_power_on_reset_oe, .fabric_domain_power_on, .shutdown_request_pin,
    .pm_gpi, .mux_io_out, .pm_gpo, .pm_gpo_oe, .rails_enable, .fabric_rails_enable, .irq);
  mpsc_carrier_model i_mpsc_carrier_model (.clock, .main_supply_ok, .fabric_rails_enable,
    .ps_power_on_reset_oe, .power_off_request_n, .fabric_rails_in_regulation,
    .ps_power_on_reset_in);

  // 100 MHz clock
  always #5 clock = ~clock;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; a read notes its expected {pslverr, prdata}
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return ps_io_supply_enable;
      1: return fabric_io_supply_enable;
      2: return ps_power_on_reset_oe;
      3: return rails_enable;
      default: return fabric_rails_enable;
    endcase
  endfunction

  // bounded wait for a level, then the level itself is compared
  task wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (sig(k) !== v && n < 400) begin
      @(posedge clock);
      n++;
    end
    check({32'h0, sig(k)}, {32'h0, v});
  endtask

  // read answers taken against the oldest note
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #200000;
    err_count++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check({rails_enable, ps_io_supply_enable, fabric_io_supply_enable}, 3'h0);
    check(ps_power_on_reset_oe, 1'b1);
    check(ps_power_on_reset_n, 1'b0);
    apb(1'b1, 12'h00C, 32'h1, 33'h0);
    shutdown_request_pin <= 1'b0; // edge while off is ignored
    repeat (20) @(posedge clock);
    check({rails_enable, ps_io_supply_enable}, 2'b00);
    main_supply_ok <= 1'b1;
    shutdown_request_pin <= 1'b1;
    wait_for(0, 1'b1);
    check(fabric_io_supply_enable, 1'b0);
    shutdown_request_pin <= 1'b0; // edge during reset hold is ignored
    wait_for(1, 1'b1);
    wait_for(2, 1'b0);
    repeat (3) @(posedge clock);
    check({ps_io_supply_enable, fabric_io_supply_enable, fabric_rails_good}, 3'h7);
    check(irq, 1'b1);
    shutdown_request_pin <= 1'b1;
    apb(1'b1, 12'h008, 32'h1, 33'h0);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0}); // unmapped place refused
    for (int i = 0; i < 4; i++) begin
      c = 3'($random(seed));
      o = 3'($random(seed));
      pm_gpi <= 6'($random(seed));
      mux_io_out <= 3'($random(seed));
      apb(1'b1, 12'h018, {29'h0, c}, 33'h0);
      apb(1'b1, 12'h010, {29'h0, o}, 33'h0);
      repeat (4) @(posedge clock);
      apb(1'b0, 12'h014, 32'h0, {27'h0, pm_gpi});
      check({pm_gpo_oe, pm_gpo}, {3'h7, (c & o) | (~c & mux_io_out)});
    end
    fab_drive <= 1'b1;
    wait_for(1, 1'b0);
    check(ps_io_supply_enable, 1'b1);
    wait_for(4, 1'b0);
    repeat (8) @(posedge clock);
    check({fabric_rails_good, irq}, 2'b00);
    apb(1'b1, 12'h00C, 32'h4, 33'h0);
    repeat (2) @(posedge clock);
    check(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h4, 33'h0);
    repeat (2) @(posedge clock);
    check(irq, 1'b0);
    fab_val <= 1'b1;
    wait_for(1, 1'b1);
    fab_drive <= 1'b0; // left to the pull-up, fabric stays on
    repeat (8) @(posedge clock);
    check({fabric_io_supply_enable, fabric_rails_good}, 2'b11);
    check(ps_power_on_reset_oe, 1'b0);
    apb(1'b1, 12'h000, 32'h2, 33'h0);
    wait_for(1, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 33'h0_0000_0729);
    apb(1'b1, 12'h000, 32'h0, 33'h0);
    wait_for(1, 1'b1);
    check(ps_power_on_reset_oe, 1'b0);
    power_down_request_n <= 1'b0;
    wait_for(1, 1'b0);
    check(ps_io_supply_enable, 1'b1);
    wait_for(3, 1'b0);
    power_down_request_n <= 1'b1;
    wait_for(0, 1'b1);
    wait_for(2, 1'b0);
    shutdown_request_pin <= 1'b0;
    wait_for(1, 1'b0);
    check(ps_io_supply_enable, 1'b1);
    wait_for(0, 1'b0);
    wait_for(3, 1'b0);
    check(exp_q.size(), 33'h0);
    finish_test();
  end
endmodule
